// File: verilog/pcg_gating.sv
// Behaviour
// - A set enable bit clocks its unit; a clear bit leaves it unclocked.
// - Access to an unclocked unit is answered with a bus fault.
// - All gating enables are zero after reset.
// - Separate run, sleep and deep-sleep copies of both gating registers.
// - Sleep copies apply in low-power modes only when auto gating is set.
// - Gating register zero bit 3 is the watchdog enable, deep copy at 0x120.
// - Gating register one bits 16, 17, 18 enable timers a, b, c.
// - Gating register one bit 12 enables the first two-wire unit.
// - Gating register one bit 4 enables the first synchronous serial unit.
// - Gating register one bits 0 and 1 enable the two async serial units.
// - Gating register one bit 24 enables the comparator; unclocked access faults.
// - Unused bits read zero and ignore writes.
// - Run copy of gating register zero sits at 0x100.
// - Sleep copy of gating register one sits at 0x114.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
module pcg_gating (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire logic periphReq,
  input wire logic [3:0] periphUnit,
  output logic periphOk,
  output logic periphFault,
  output logic [8:0] unitClkEn,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel, input logic [31:0] keep);
    logic [31:0] byteMask;
    byteMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wrMerge = ((old & ~byteMask) | (nw & byteMask)) & keep;
  endfunction

  function automatic logic [8:0] unitVec(input logic [31:0] r0, input logic [31:0] r1);
    unitVec = {r1[pcg_pkg::PCG_BIT_CMP], r1[pcg_pkg::PCG_BIT_UART2], r1[pcg_pkg::PCG_BIT_ASYNC_SERIAL_SECOND_CLK_EN],
               r1[pcg_pkg::PCG_BIT_SSER], r1[pcg_pkg::PCG_BIT_TWI], r1[pcg_pkg::PCG_BIT_TMRC],
               r1[pcg_pkg::PCG_BIT_TMRB], r1[pcg_pkg::PCG_BIT_TMRA], r0[pcg_pkg::PCG_BIT_WDOG]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One copy per power mode for each gating register
  logic [31:0] run0_q;
  logic [31:0] run1_q;
  logic [31:0] slp0_q;
  logic [31:0] slp1_q;
  logic [31:0] dsl0_q;
  logic [31:0] dsl1_q;
  logic [31:0] rcfg_q;
  logic [31:0] istat_q;
  logic [31:0] imask_q;
  logic [31:0] rdData_q;
  logic ack_q;
  logic ok_q;
  logic fault_q;
  logic irq_q;
  logic [8:0] clkEn_q;
  pcg_pkg::pcg_mode_t mode_q;

  wire busReq = wb_cyc_i & wb_stb_i;
  wire wrEn = busReq & wb_we_i & ack_q;
  wire hitRun0 = wb_adr_i == pcg_pkg::PCG_OFS_RUN0;
  wire hitRun1 = wb_adr_i == pcg_pkg::PCG_OFS_RUN1;
  wire hitSlp0 = wb_adr_i == pcg_pkg::PCG_OFS_SLP0;
  wire hitSlp1 = wb_adr_i == pcg_pkg::PCG_OFS_SLP1;
  wire hitDsl0 = wb_adr_i == pcg_pkg::PCG_OFS_DSL0;
  wire hitDsl1 = wb_adr_i == pcg_pkg::PCG_OFS_DSL1;
  wire hitRcfg = wb_adr_i == pcg_pkg::PCG_OFS_RCFG;
  wire hitIstat = wb_adr_i == pcg_pkg::PCG_OFS_ISTAT;
  wire hitImask = wb_adr_i == pcg_pkg::PCG_OFS_IMASK;

  // Unmapped addresses read as zero and ignore writes
  wire [31:0] rdMux = hitRun0 ? run0_q : hitRun1 ? run1_q : hitSlp0 ? slp0_q :
                      hitSlp1 ? slp1_q : hitDsl0 ? dsl0_q : hitDsl1 ? dsl1_q :
                      hitRcfg ? rcfg_q : hitIstat ? istat_q : hitImask ? imask_q :
                      pcg_pkg::PCG_RST_REG;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and effective enables
  wire autoGate = rcfg_q[pcg_pkg::PCG_BIT_AUTO];
  // Deep sleep wins when both requests stand
  pcg_pkg::pcg_mode_t mode_d;
  assign mode_d = deepSleepReq ? pcg_pkg::PCG_DEEP : sleepReq ? pcg_pkg::PCG_SLEEP : pcg_pkg::PCG_RUN;
  wire [8:0] enRun = unitVec(run0_q, run1_q);
  wire [8:0] enSlp = unitVec(slp0_q, slp1_q);
  wire [8:0] enDsl = unitVec(dsl0_q, dsl1_q);
  // Low-power copies only take over under auto gating
  wire [8:0] clkEn_d = (autoGate && mode_q == pcg_pkg::PCG_DEEP) ? enDsl :
                       (autoGate && mode_q == pcg_pkg::PCG_SLEEP) ? enSlp : enRun;
  wire modeEvt = mode_d != mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral access check; unit codes past the last unit also fault
  wire unitValid = periphUnit <= pcg_pkg::PCG_U_CMP;
  wire unitOn = unitValid & clkEn_q[periphUnit];
  wire faultEvt = periphReq & ~unitOn;

  wire [31:0] evtVec = {30'h00000000, modeEvt, faultEvt};
  wire [31:0] clrVec = (wrEn && hitIstat) ? wrMerge(32'h00000000, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_INT)
                                          : 32'h00000000;
  // A new event wins over a clear in the same cycle
  wire [31:0] istat_d = ((istat_q & ~clrVec) | evtVec) & pcg_pkg::PCG_MASK_INT;
  wire irq_d = |(istat_d & imask_q);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdData_q <= pcg_pkg::PCG_RST_REG;
    end else begin
      ack_q <= busReq & ~ack_q;
      rdData_q <= (busReq & ~ack_q) ? rdMux : rdData_q;
    end
  end

  // Gating copies, each bit writable only where a unit exists; config and mask registers by their own masks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run0_q <= pcg_pkg::PCG_RST_REG;
      run1_q <= pcg_pkg::PCG_RST_REG;
      slp0_q <= pcg_pkg::PCG_RST_REG;
      slp1_q <= pcg_pkg::PCG_RST_REG;
      dsl0_q <= pcg_pkg::PCG_RST_REG;
      dsl1_q <= pcg_pkg::PCG_RST_REG;
      rcfg_q <= pcg_pkg::PCG_RST_REG;
      imask_q <= pcg_pkg::PCG_RST_REG;
    end else if (wrEn) begin
      if (hitRun0) run0_q <= wrMerge(run0_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ZERO);
      if (hitRun1) run1_q <= wrMerge(run1_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ONE);
      if (hitSlp0) slp0_q <= wrMerge(slp0_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ZERO);
      if (hitSlp1) slp1_q <= wrMerge(slp1_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ONE);
      if (hitDsl0) dsl0_q <= wrMerge(dsl0_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ZERO);
      if (hitDsl1) dsl1_q <= wrMerge(dsl1_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_ONE);
      if (hitRcfg) rcfg_q <= wrMerge(rcfg_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_RCFG);
      if (hitImask) imask_q <= wrMerge(imask_q, wb_dat_i, wb_sel_i, pcg_pkg::PCG_MASK_INT);
    end
  end

  // Enables only change on a clock edge, so the downstream gate cells see no glitch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= pcg_pkg::PCG_RUN;
      clkEn_q <= 9'h000;
      istat_q <= pcg_pkg::PCG_RST_REG;
      irq_q <= 1'b0;
      ok_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      clkEn_q <= clkEn_d;
      istat_q <= istat_d;
      irq_q <= irq_d;
      ok_q <= periphReq & unitOn;
      fault_q <= faultEvt;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;
  assign unitClkEn = clkEn_q;
  assign periphOk = ok_q;
  assign periphFault = fault_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  a_fault_when_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    periphReq && unitValid && !clkEn_q[periphUnit] |=> periphFault && !periphOk)
    else $error("access to gated unit not faulted");

  a_ok_when_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    periphReq && unitValid && clkEn_q[periphUnit] |=> periphOk && !periphFault)
    else $error("access to clocked unit faulted");

  a_run_copy_rules: assert property (@(posedge core_clk) disable iff (!rst_n)
    !autoGate |=> unitClkEn == $past(enRun))
    else $error("run copy not applied without auto gating");

  a_deep_copy_use: assert property (@(posedge core_clk) disable iff (!rst_n)
    autoGate && mode_q == pcg_pkg::PCG_DEEP |=> unitClkEn == $past(enDsl))
    else $error("deep copy not applied");

  a_sleep_copy_use: assert property (@(posedge core_clk) disable iff (!rst_n)
    autoGate && mode_q == pcg_pkg::PCG_SLEEP |=> unitClkEn == $past(enSlp))
    else $error("sleep copy not applied");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((run1_q | slp1_q | dsl1_q) & ~pcg_pkg::PCG_MASK_ONE) == 32'h00000000 &&
    ((run0_q | slp0_q | dsl0_q) & ~pcg_pkg::PCG_MASK_ZERO) == 32'h00000000)
    else $error("reserved gating bit set");

  a_timer_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun1 && wb_sel_i[2] |=> run1_q[pcg_pkg::PCG_BIT_TMRC:pcg_pkg::PCG_BIT_TMRA] == $past(wb_dat_i[18:16]))
    else $error("timer enables not written");

  a_wdog_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitDsl0 && wb_sel_i[0] |=> dsl0_q[pcg_pkg::PCG_BIT_WDOG] == $past(wb_dat_i[3]))
    else $error("deep watchdog enable not written");

  a_ack_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 irq == $past(irq_d))
    else $error("irq does not follow masked status");

  a_irq_masked_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    imask_q == pcg_pkg::PCG_RST_REG |=> !irq)
    else $error("irq raised with every source masked");

  a_fault_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    faultEvt |=> istat_q[pcg_pkg::PCG_BIT_EV_FAULT])
    else $error("faulted access left no status flag");

  a_mode_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    modeEvt |=> istat_q[pcg_pkg::PCG_BIT_EV_MODE])
    else $error("mode change left no status flag");

  // Clearing only takes hold when no new fault lands in the same cycle
  a_status_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitIstat && wb_sel_i[0] && wb_dat_i[pcg_pkg::PCG_BIT_EV_FAULT] && !faultEvt
    |=> !istat_q[pcg_pkg::PCG_BIT_EV_FAULT])
    else $error("fault flag survived its clear");

  a_ok_fault_excl: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(periphOk && periphFault))
    else $error("access answered both ok and fault");

  a_bad_unit_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    periphReq && !unitValid |=> periphFault && !periphOk)
    else $error("access to unknown unit not faulted");

  a_idle_no_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    !periphReq |=> !periphOk && !periphFault)
    else $error("access answer without a request");

  a_cmp_fault_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    periphReq && periphUnit == pcg_pkg::PCG_U_CMP && !clkEn_q[pcg_pkg::PCG_U_CMP] |=> periphFault)
    else $error("access to gated comparator not faulted");

  a_run_wdog_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun0 && wb_sel_i[0] |=> run0_q[pcg_pkg::PCG_BIT_WDOG] == $past(wb_dat_i[pcg_pkg::PCG_BIT_WDOG]))
    else $error("run watchdog enable not written");

  a_twowire_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun1 && wb_sel_i[1] |=> run1_q[pcg_pkg::PCG_BIT_TWI] == $past(wb_dat_i[pcg_pkg::PCG_BIT_TWI]))
    else $error("two-wire enable not written");

  a_sync_serial_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun1 && wb_sel_i[0] |=> run1_q[pcg_pkg::PCG_BIT_SSER] == $past(wb_dat_i[pcg_pkg::PCG_BIT_SSER]))
    else $error("sync serial enable not written");

  a_async_serial_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun1 && wb_sel_i[0] |=> run1_q[pcg_pkg::PCG_BIT_UART2:pcg_pkg::PCG_BIT_ASYNC_SERIAL_SECOND_CLK_EN] == $past(wb_dat_i[1:0]))
    else $error("async serial enables not written");

  a_cmp_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitRun1 && wb_sel_i[3] |=> run1_q[pcg_pkg::PCG_BIT_CMP] == $past(wb_dat_i[pcg_pkg::PCG_BIT_CMP]))
    else $error("comparator enable not written");

  a_sleep_timer_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitSlp1 && wb_sel_i[2] |=> slp1_q[pcg_pkg::PCG_BIT_TMRC:pcg_pkg::PCG_BIT_TMRA] == $past(wb_dat_i[18:16]))
    else $error("sleep timer enables not written");

  a_copies_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wrEn |=> $stable(run0_q) && $stable(run1_q) && $stable(slp0_q) && $stable(slp1_q) &&
              $stable(dsl0_q) && $stable(dsl1_q))
    else $error("gating copy changed without a write");

  a_copy_isolated: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrEn && hitSlp1 |=> $stable(run1_q) && $stable(dsl1_q))
    else $error("sleep write disturbed another copy");

  a_deep_mode_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    deepSleepReq |=> mode_q == pcg_pkg::PCG_DEEP)
    else $error("deep sleep request not taken");

  a_sleep_mode_take: assert property (@(posedge core_clk) disable iff (!rst_n)
    sleepReq && !deepSleepReq |=> mode_q == pcg_pkg::PCG_SLEEP)
    else $error("sleep request not taken");

  a_run_mode_take: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sleepReq && !deepSleepReq |=> mode_q == pcg_pkg::PCG_RUN)
    else $error("run mode not restored");

  a_ack_after_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    busReq && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");

  a_ack_needs_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    !busReq |=> !wb_ack_o)
    else $error("ack without a request");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(busReq && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data changed outside an access");

endmodule

// File: verilog/pcg_pkg.sv
package pcg_pkg;
  localparam int unsigned PCG_CLK_HZ = 50000000;
  localparam int unsigned PCG_UNITS = 9;

  localparam logic [11:0] PCG_OFS_RUN0 = 12'h100;
  localparam logic [11:0] PCG_OFS_RUN1 = 12'h104;
  localparam logic [11:0] PCG_OFS_SLP0 = 12'h110;
  localparam logic [11:0] PCG_OFS_SLP1 = 12'h114;
  localparam logic [11:0] PCG_OFS_DSL0 = 12'h120;
  localparam logic [11:0] PCG_OFS_DSL1 = 12'h124;
  localparam logic [11:0] PCG_OFS_RCFG = 12'h060;
  localparam logic [11:0] PCG_OFS_ISTAT = 12'h140;
  localparam logic [11:0] PCG_OFS_IMASK = 12'h144;

  localparam int unsigned PCG_BIT_WDOG = 3;
  localparam int unsigned PCG_BIT_ASYNC_SERIAL_SECOND_CLK_EN = 0;
  localparam int unsigned PCG_BIT_UART2 = 1;
  localparam int unsigned PCG_BIT_SSER = 4;
  localparam int unsigned PCG_BIT_TWI = 12;
  localparam int unsigned PCG_BIT_TMRA = 16;
  localparam int unsigned PCG_BIT_TMRB = 17;
  localparam int unsigned PCG_BIT_TMRC = 18;
  localparam int unsigned PCG_BIT_CMP = 24;
  localparam int unsigned PCG_BIT_AUTO = 0;
  localparam int unsigned PCG_BIT_EV_FAULT = 0;
  localparam int unsigned PCG_BIT_EV_MODE = 1;

  localparam logic [31:0] PCG_MASK_ZERO = 32'h00000008;
  localparam logic [31:0] PCG_MASK_ONE = 32'h01071013;
  localparam logic [31:0] PCG_MASK_RCFG = 32'h00000001;
  localparam logic [31:0] PCG_MASK_INT = 32'h00000003;
  localparam logic [31:0] PCG_RST_REG = 32'h00000000;

  // Unit indices on the enable vector and on the access port
  localparam logic [3:0] PCG_U_WDOG = 4'h0;
  localparam logic [3:0] PCG_U_TMRA = 4'h1;
  localparam logic [3:0] PCG_U_TMRB = 4'h2;
  localparam logic [3:0] PCG_U_TMRC = 4'h3;
  localparam logic [3:0] PCG_U_TWI = 4'h4;
  localparam logic [3:0] PCG_U_SSER = 4'h5;
  localparam logic [3:0] PCG_U_ASYNC_SERIAL_SECOND_CLK_EN = 4'h6;
  localparam logic [3:0] PCG_U_UART2 = 4'h7;
  localparam logic [3:0] PCG_U_CMP = 4'h8;

  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_t;
endpackage

// File: sim/pcg_periph_model.sv
`timescale 1ns/1ns
module pcg_periph_model (
  input wire logic core_clk,
  output logic periphReq,
  output logic [3:0] periphUnit,
  input wire logic periphOk,
  input wire logic periphFault
);
  initial begin
    periphReq = 1'b0;
    periphUnit = 4'hF;
  end
  // Between accesses the unit index is inverted so nothing leans on a stale value
  task automatic access(input logic [3:0] unit, output logic ok, output logic fault);
    periphReq <= 1'b1;
    periphUnit <= unit;
    @(posedge core_clk);
    periphReq <= 1'b0;
    periphUnit <= ~unit;
    #1;
    ok = periphOk;
    fault = periphFault;
  endtask
endmodule

// File: sim/test_peripheral_clock_gating.sv
`timescale 1ns/1ns
module test_peripheral_clock_gating;
  typedef struct packed {logic [11:0] adr; logic [31:0] wr; logic [31:0] rd;} pcg_row_t;
  logic coreClk, rstN, wbCyc, wbStb, wbWe, wbAck, sleepReq, deepSleepReq, periphReq, periphOk, periphFault, irq;
  logic [11:0] wbAdr;
  logic [31:0] wbDat, wbDatO, rd;
  logic [3:0] wbSel, periphUnit;
  logic [8:0] unitClkEn;
  logic ok, flt;
  int nFail = 0;
  int numChecks = 0;
  pcg_row_t rows[9] = '{
    '{pcg_pkg::PCG_OFS_RUN0, 32'hFFFFFFFF, 32'h00000008}, '{pcg_pkg::PCG_OFS_RUN1, 32'hFFFFFFFF, 32'h01071013},
    '{pcg_pkg::PCG_OFS_SLP0, 32'h00000000, 32'h00000000}, '{pcg_pkg::PCG_OFS_SLP1, 32'h01000001, 32'h01000001},
    '{pcg_pkg::PCG_OFS_DSL0, 32'hFFFFFFF7, 32'h00000000}, '{pcg_pkg::PCG_OFS_DSL1, 32'h00070000, 32'h00070000},
    '{pcg_pkg::PCG_OFS_RCFG, 32'hFFFFFFFF, 32'h00000001}, '{pcg_pkg::PCG_OFS_IMASK, 32'h00000000, 32'h00000000},
    '{12'h200, 32'hFFFFFFFF, 32'h00000000}};
  pcg_gating dut (.core_clk(coreClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .periphReq(periphReq), .periphUnit(periphUnit),
    .periphOk(periphOk), .periphFault(periphFault), .unitClkEn(unitClkEn), .irq(irq));
  pcg_periph_model pm (.core_clk(coreClk), .periphReq(periphReq), .periphUnit(periphUnit),
    .periphOk(periphOk), .periphFault(periphFault));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The slave's latency is not assumed; the wait ends on ack or after 50 cycles
  task automatic wb(input logic [11:0] adr, input logic we, input logic [31:0] dat, output logic [31:0] q);
    int n;
    @(posedge coreClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= dat;
    wbSel <= 4'hF;
    n = 0;
    do begin
      @(posedge coreClk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      chk("bus ack", 32'h1, 32'h0);
      give_verdict();
    end
  endtask
  function automatic logic [8:0] expEn(input logic [31:0] r0, input logic [31:0] r1);
    expEn = {r1[24], r1[1], r1[0], r1[4], r1[12], r1[18], r1[17], r1[16], r0[3]};
  endfunction
  // Enables follow a mode change two cycles later; one spare cycle is allowed
  task automatic modeChk(input logic s, input logic d, input logic [8:0] exp, input string nm);
    @(posedge coreClk);
    sleepReq <= s;
    deepSleepReq <= d;
    repeat (3) @(posedge coreClk);
    #1;
    chk(nm, 32'(exp), 32'(unitClkEn));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    coreClk = 1'b0;
    forever #10 coreClk = ~coreClk;
  end
  initial begin
    {rstN, wbCyc, wbStb, wbWe, sleepReq, deepSleepReq} = '0;
    wbAdr = '0;
    wbDat = '0;
    wbSel = '0;
    repeat (20) @(posedge coreClk);
    rstN <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].adr, 1'b1, rows[i].wr, rd);
      wb(rows[i].adr, 1'b0, 32'h0, rd);
      chk("register readback", rows[i].rd, rd);
    end
    $display("register table done");
    modeChk(1'b0, 1'b0, expEn(rows[0].rd, rows[1].rd), "run enables");
    modeChk(1'b1, 1'b0, expEn(rows[2].rd, rows[3].rd), "sleep enables");
    modeChk(1'b1, 1'b1, expEn(rows[4].rd, rows[5].rd), "deep enables");
    for (int u = 0; u < 10; u++) begin
      @(posedge coreClk);
      pm.access(4'(u), ok, flt);
      chk("unit ok", 32'(u < 9 && expEn(rows[4].rd, rows[5].rd) >> u & 1), 32'(ok));
      chk("unit fault", 32'(!(u < 9 && expEn(rows[4].rd, rows[5].rd) >> u & 1)), 32'(flt));
    end
    wb(pcg_pkg::PCG_OFS_ISTAT, 1'b0, 32'h0, rd);
    chk("event status", 32'h00000003, rd);
    chk("masked irq", 32'h0, 32'(irq));
    wb(pcg_pkg::PCG_OFS_IMASK, 1'b1, 32'h00000001, rd);
    repeat (2) @(posedge coreClk);
    chk("unmasked irq", 32'h1, 32'(irq));
    wb(pcg_pkg::PCG_OFS_ISTAT, 1'b1, 32'h00000001, rd);
    repeat (2) @(posedge coreClk);
    chk("cleared irq", 32'h0, 32'(irq));
    wb(pcg_pkg::PCG_OFS_ISTAT, 1'b0, 32'h0, rd);
    chk("status after clear", 32'h00000002, rd);
    $display("access and interrupt done");
    wb(pcg_pkg::PCG_OFS_RCFG, 1'b1, 32'h00000000, rd);
    modeChk(1'b1, 1'b1, expEn(rows[0].rd, rows[1].rd), "auto off in deep");
    @(posedge coreClk);
    rstN <= 1'b0;
    sleepReq <= 1'b0;
    deepSleepReq <= 1'b0;
    @(posedge coreClk);
    #1;
    chk("enables in reset", 32'h0, 32'(unitClkEn));
    @(posedge coreClk);
    rstN <= 1'b1;
    wb(pcg_pkg::PCG_OFS_RUN1, 1'b0, 32'h0, rd);
    chk("run one after reset", 32'h0, rd);
    wb(pcg_pkg::PCG_OFS_DSL0, 1'b0, 32'h0, rd);
    chk("deep zero after reset", 32'h0, rd);
    $display("reset done");
    give_verdict();
  end
endmodule
